// [iuos_pkg.sv]
/*
 * Shared constants of the interrupt unit operation and status block:
 * port offsets, command field positions and values after reset.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package iuos_pkg;
    // Number of request inputs
    localparam int unsigned NUM_LEVELS = 8;

    // Port offsets on the byte-wide port pair
    localparam logic PORT_CMD_STATUS = 1'b0; // Commands in, status out
    localparam logic PORT_MASK       = 1'b1; // Mask word in and out

    // Word type marker bits on the lower port
    localparam int unsigned TYPE_MODE_BIT = 3; // Set: mode word
    localparam int unsigned TYPE_INIT_BIT = 4; // Set: init word, not handled

    // Priority-and-finish word fields
    localparam int unsigned PF_LVL_LSB = 0;
    localparam int unsigned PF_FI_BIT  = 5;
    localparam int unsigned PF_SIL_BIT = 6;
    localparam int unsigned PF_RP_BIT  = 7;

    // Mode word fields
    localparam int unsigned MD_IS_BIT   = 0; // 1 = in-service, 0 = request
    localparam int unsigned MD_SR_BIT   = 1; // Status read enable
    localparam int unsigned MD_POLL_BIT = 2; // Poll command
    localparam int unsigned MD_NESTING_TOGGLE_BIT_BIT = 5; // Nesting toggle
    localparam int unsigned MD_SNM_BIT  = 6; // Nesting arm

    // Poll word layout
    localparam int unsigned POLL_PRESENT_BIT = 7;
    localparam logic [7:0]  POLL_EMPTY       = 8'h07;

    // Values after reset
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [2:0] BASE_RST = 3'h7; // Level 7 lowest, level 0 highest
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Synchroniser depth for request pins
    localparam int unsigned SYNC_STAGES = 2;
endpackage : iuos_pkg

// [iuos_req_sync.sv]
/*
 * Request pin synchroniser and rising edge detector, one lane per input.
 * Assumes the pins are asynchronous to clk_sys_in.
 */
module iuos_req_sync
    import iuos_pkg::*;
#(
    parameter int unsigned WIDTH = NUM_LEVELS
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] rise_out
);
    // Elaboration check: a lane count of zero leaves nothing to build
    if (WIDTH < 1) begin : g_bad_width
        $error("iuos_req_sync: WIDTH must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // One lane per input; first stage is read by the second stage only
    for (genvar g = 0; g < WIDTH; g++) begin : g_lane
        logic meta_q;  // First stage, may be metastable
        logic sync_q;  // Second stage, safe to use
        logic last_q;  // Previous safe value
        logic meta_d;
        logic sync_d;
        logic last_d;

        // Next values of the lane
        always_comb begin
            meta_d = pin_in[g];
            sync_d = meta_q;
            last_d = sync_q;
        end

        // Lane registers
        always_ff @(posedge clk_sys_in or posedge reset_in) begin
            if (reset_in) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
                last_q <= 1'b0;
            end else begin
                meta_q <= meta_d;
                sync_q <= sync_d;
                last_q <= last_d;
            end
        end

        // Edge only from the safe stages
        assign rise_out[g] = sync_q & ~last_q;
    end
endmodule : iuos_req_sync

// [iuos_top.sv]
/*
 * Operation and status part of an eight-input interrupt unit: priority
 * and finish commands, mode word, request/in-service/poll status reads.
 * Assumes a host on the same clock issuing one-cycle read and write
 * strobes on a byte-wide port pair, and asynchronous request pins.
 */
// Functional notes
// - Level field names level to clear or prioritise
// - In-service register changes on finish commands
// - Specific, non-specific and automatic finish supported
// - Finish bit set performs specific or non-specific finish
// - Specific bit uses level field for clear/rotate
// - Rotate bit set rotates, clear never rotates
// - Mode bit0 picks in-service/request; bit1 enables
// - Poll bit selects poll word over status enable
// - Arm bit lets toggle enter/leave special nesting
// - Selected status stays until new mode word
// - Status bit n maps to request input n
// - Poll code names highest unmasked pending level; nesting skips levels in service
// - No request: present flag 0, code all ones
// - New priority word takes effect immediately
// - Masked request latched, never goes in-service
// - Two byte ports: commands/status low, mask high
// - Every transfer is eight bits wide
module iuos_top
    import iuos_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] irq_pin_in,     // Asynchronous request pins
    input  wire logic       sel_in,         // Port pair selected
    input  wire logic       addr_in,        // 0 lower port, 1 upper port
    input  wire logic       wr_in,          // One-cycle write strobe
    input  wire logic       rd_in,          // One-cycle read strobe
    input  wire logic [7:0] wdata_in,       // Write byte
    input  wire logic       ack_in,         // One-cycle acknowledge
    input  wire logic       auto_finish_in, // Automatic finish enabled
    output logic      [7:0] rdata_out,      // Read byte, registered
    output logic            int_out,        // Request to the CPU
    output logic      [2:0] ack_level_out   // Level granted at last ack
);
    ////////////////////////////////////////////////////////////////////////
    // Priority helpers
    // Highest priority set bit given the lowest priority level
    function automatic logic [3:0] top_of(input logic [7:0] v,
                                          input logic [2:0] b);
        logic [2:0] idx;
        top_of = 4'h0;
        // Walk from lowest priority up so the last hit wins
        for (int i = 8; i >= 1; i--) begin
            idx = b + 3'(i);
            if (v[idx]) begin
                top_of = {1'b1, idx};
            end
        end
    endfunction : top_of

    // Rank of a level, 0 is highest priority
    function automatic logic [2:0] rank_of(input logic [2:0] l,
                                           input logic [2:0] b);
        rank_of = l - b - 3'h1;
    endfunction : rank_of

    ////////////////////////////////////////////////////////////////////////
    // Request pins
    logic [7:0] rise;  // One-cycle request edges

    iuos_req_sync #(
        .WIDTH (NUM_LEVELS)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .pin_in     (irq_pin_in),
        .rise_out   (rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    logic       wr_lo;     // Write to lower port
    logic       pfw_wr;    // Priority-and-finish word written
    logic       mode_wr;   // Mode word written
    logic       mask_wr;   // Mask word written
    logic       fi_b;      // Finish bit
    logic       sil_b;     // Specific level bit
    logic       rp_b;      // Rotate bit
    logic [2:0] lvl_f;     // Level field

    // Init words (type bit 4) are outside this block and ignored
    always_comb begin
        wr_lo   = sel_in && wr_in && (addr_in == PORT_CMD_STATUS)
                  && !wdata_in[TYPE_INIT_BIT];
        pfw_wr  = wr_lo && !wdata_in[TYPE_MODE_BIT];
        mode_wr = wr_lo && wdata_in[TYPE_MODE_BIT];
        mask_wr = sel_in && wr_in && (addr_in == PORT_MASK);
        fi_b    = wdata_in[PF_FI_BIT];
        sil_b   = wdata_in[PF_SIL_BIT];
        rp_b    = wdata_in[PF_RP_BIT];
        lvl_f   = wdata_in[PF_LVL_LSB +: 3];
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt state
    logic [7:0] irr_q, irr_d;       // Pending requests
    logic [7:0] isr_q, isr_d;       // Levels in service
    logic [7:0] mask_q, mask_d;     // Mask word
    logic [2:0] base_q, base_d;     // Lowest priority level
    logic       rot_auto_q, rot_auto_d; // Rotate on automatic finish
    logic       nest_q, nest_d;     // Special nesting active
    logic [2:0] ackl_q, ackl_d;     // Last granted level

    logic [3:0] req_top;  // Best unmasked request
    logic [3:0] isr_top;  // Best level in service
    logic       int_raw;  // Request may reach the CPU
    logic       grant;    // Acknowledge taken

    // Arbitration against the levels in service
    always_comb begin
        logic [7:0] cand;
        cand = irr_q & ~mask_q;
        // Nesting mode only blocks the very level in service
        if (nest_q) begin
            cand = cand & ~isr_q;
        end
        req_top = top_of(cand, base_q);
        isr_top = top_of(isr_q, base_q);
        int_raw = req_top[3];
        if (!nest_q && isr_top[3]) begin
            int_raw = req_top[3] && (rank_of(req_top[2:0], base_q)
                      < rank_of(isr_top[2:0], base_q));
        end
        grant = ack_in && int_raw;
    end

    // Next values of the interrupt state
    always_comb begin
        irr_d      = irr_q;
        isr_d      = isr_q;
        mask_d     = mask_q;
        base_d     = base_q;
        rot_auto_d = rot_auto_q;
        nest_d     = nest_q;
        ackl_d     = ackl_q;
        // Finish and rotate commands act in the write cycle
        if (pfw_wr) begin
            case ({rp_b, sil_b, fi_b})
                3'b001: begin // Non-specific finish
                    if (isr_top[3]) isr_d[isr_top[2:0]] = 1'b0;
                end
                3'b011: begin // Specific finish
                    isr_d[lvl_f] = 1'b0;
                end
                3'b101: begin // Rotate on non-specific finish
                    if (isr_top[3]) begin
                        isr_d[isr_top[2:0]] = 1'b0;
                        base_d = isr_top[2:0];
                    end
                end
                3'b111: begin // Rotate on specific finish
                    isr_d[lvl_f] = 1'b0;
                    base_d       = lvl_f;
                end
                3'b110: base_d = lvl_f;      // Set priority
                3'b100: rot_auto_d = 1'b1;   // Rotate on auto finish
                3'b000: rot_auto_d = 1'b0;   // Stop rotate on auto
                default: ;                   // No operation
            endcase
        end
        if (mask_wr) begin
            mask_d = wdata_in;
        end
        if (mode_wr && wdata_in[MD_SNM_BIT]) begin
            nest_d = wdata_in[MD_NESTING_TOGGLE_BIT_BIT];
        end
        // Acknowledge clears the request; it goes into service unless automatic finish is on
        if (grant) begin
            irr_d[req_top[2:0]] = 1'b0;
            ackl_d = req_top[2:0];
            if (auto_finish_in) begin
                if (rot_auto_q) base_d = req_top[2:0];
            end else begin
                isr_d[req_top[2:0]] = 1'b1;
            end
        end
        // New edges win over a clear in the same cycle
        irr_d = irr_d | rise;
    end

    // Interrupt state registers
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            irr_q      <= 8'h00;
            isr_q      <= 8'h00;
            mask_q     <= MASK_RST;
            base_q     <= BASE_RST;
            rot_auto_q <= 1'b0;
            nest_q     <= 1'b0;
            ackl_q     <= 3'h0;
        end else begin
            irr_q      <= irr_d;
            isr_q      <= isr_d;
            mask_q     <= mask_d;
            base_q     <= base_d;
            rot_auto_q <= rot_auto_d;
            nest_q     <= nest_d;
            ackl_q     <= ackl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status selection and reads
    logic       sel_poll_q, sel_poll_d; // Poll word selected
    logic       sel_en_q, sel_en_d;     // Status read enabled
    logic       sel_is_q, sel_is_d;     // In-service chosen
    logic [7:0] rdata_q, rdata_d;       // Read byte
    logic [7:0] poll_word;              // Poll word now

    // Selection holds until a mode word picks another word
    always_comb begin
        sel_poll_d = sel_poll_q;
        sel_en_d   = sel_en_q;
        sel_is_d   = sel_is_q;
        if (mode_wr && wdata_in[MD_POLL_BIT]) begin
            sel_poll_d = 1'b1;
        end else if (mode_wr && wdata_in[MD_SR_BIT]) begin
            sel_poll_d = 1'b0;
            sel_en_d   = 1'b1;
            sel_is_d   = wdata_in[MD_IS_BIT];
        end
        // Poll word built from live requests
        if (req_top[3]) begin
            poll_word = {1'b1, 4'h0, req_top[2:0]};
        end else begin
            poll_word = POLL_EMPTY;
        end
        rdata_d = rdata_q;
        if (sel_in && rd_in) begin
            if (addr_in == PORT_MASK) begin
                rdata_d = mask_q;
            end else if (sel_poll_q) begin
                rdata_d = poll_word;
            end else if (!sel_en_q) begin
                rdata_d = 8'h00; // Nothing readable yet
            end else if (sel_is_q) begin
                rdata_d = isr_q;
            end else begin
                rdata_d = irr_q;
            end
        end
    end

    // Selection and read registers
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sel_poll_q <= 1'b0;
            sel_en_q   <= 1'b0;
            sel_is_q   <= 1'b0;
            rdata_q    <= RDATA_RST;
        end else begin
            sel_poll_q <= sel_poll_d;
            sel_en_q   <= sel_en_d;
            sel_is_q   <= sel_is_d;
            rdata_q    <= rdata_d;
        end
    end

    assign rdata_out     = rdata_q;
    assign int_out       = int_raw;
    assign ack_level_out = ackl_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // In service only changes on a finish command or a grant
    a_isr_change_cause: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (isr_q != $past(isr_q)) |-> $past(pfw_wr || grant))
        else $error("In-service changed without cause");
    // Specific finish clears the named level
    a_spec_finish_clr: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (pfw_wr && {rp_b, sil_b, fi_b} == 3'b011 && !grant)
        |=> !isr_q[$past(lvl_f)])
        else $error("Specific finish left level in service");
    // Non-specific finish clears the top level in service
    a_nonspec_clr: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (pfw_wr && {rp_b, sil_b, fi_b} == 3'b001 && isr_top[3] && !grant)
        |=> !isr_q[$past(isr_top[2:0])])
        else $error("Non-specific finish missed the top level");
    // Without the rotate bit the priority base stays put
    a_no_rotate: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (pfw_wr && !rp_b && !(grant && rot_auto_q && auto_finish_in))
        |=> base_q == $past(base_q))
        else $error("Priority moved without rotate");
    // Empty poll word reads as all ones code; masked requests do not count
    a_poll_empty: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (sel_in && rd_in && !addr_in && sel_poll_q && (irr_q & ~mask_q) == 8'h00)
        |=> rdata_out == 8'h07)
        else $error("Empty poll word wrong");
    // Poll bit wins and holds over later plain reads
    a_poll_wins: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (mode_wr && wdata_in[2] && wdata_in[1]) ##1 (!mode_wr)[*2]
        |-> sel_poll_q)
        else $error("Poll selection lost");
    // Request status read returns the request register
    a_req_status: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (sel_in && rd_in && !addr_in && !sel_poll_q && sel_en_q
         && !sel_is_q) |=> rdata_out == $past(irr_q))
        else $error("Request status read mismatch");
    // Masked levels never enter service
    a_masked_no_isr: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        ((isr_d & ~isr_q & mask_q) == 8'h00))
        else $error("Masked level went in service");
    // Fixed priority favours the lowest numbered request
    a_fixed_order: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (base_q == 3'h7 && req_top[3] && !nest_q)
        |-> ((irr_q & ~mask_q & ((8'h01 << req_top[2:0]) - 8'h01)) == 8'h00))
        else $error("Fixed priority order broken");
    // Arm bit sets or releases nesting
    a_nest_arm: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (mode_wr && wdata_in[6]) |=> nest_q == $past(wdata_in[5]))
        else $error("Nesting toggle not applied");
    c_grant: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        grant ##[1:20] (pfw_wr && fi_b));
    c_poll_hit: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        sel_in && rd_in && sel_poll_q && req_top[3]);
    c_rotate: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        base_q != $past(base_q));
    c_nest: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        nest_q && grant && isr_q != 8'h00);
endmodule : iuos_top

// [iuos_host_model.sv]
/*
 * Host processor model: issues byte reads and writes on the port pair
 * and pulses the interrupt acknowledge.
 * Assumes the unit samples strobes on the rising edge of clk_sys_in.
 */
module iuos_host_model
    import iuos_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    output logic            sel_out,
    output logic            addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output logic      [7:0] wdata_out,
    output logic            ack_out
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        sel_out   = 1'b0;
        addr_out  = 1'b0;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 8'h00;
        ack_out   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One byte write, strobe held for exactly one edge
    task automatic write_port(input logic a, input logic [7:0] d);
        @(posedge clk_sys_in);
        sel_out   <= 1'b1;
        addr_out  <= a;
        wr_out    <= 1'b1;
        wdata_out <= d;
        @(posedge clk_sys_in);
        sel_out   <= 1'b0;
        wr_out    <= 1'b0;
        wdata_out <= ~d; // Released data must not look like the last byte
    endtask : write_port

    ////////////////////////////////////////////////////////////////////////////
    // One byte read; data taken once the registered answer has settled
    task automatic read_port(input logic a, output logic [7:0] d);
        @(posedge clk_sys_in);
        sel_out  <= 1'b1;
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_sys_in);
        sel_out  <= 1'b0;
        rd_out   <= 1'b0;
        @(posedge clk_sys_in);
        d = rdata_in;
    endtask : read_port

    ////////////////////////////////////////////////////////////////////////////
    // Poll sequence: select poll word, then read it
    task automatic poll_read(output logic [7:0] d);
        // Status enable set too: the poll bit must still win
        write_port(PORT_CMD_STATUS, 8'h0e);
        read_port(PORT_CMD_STATUS, d);
    endtask : poll_read

    // Single-cycle acknowledge pulse
    task automatic ack_pulse();
        @(posedge clk_sys_in);
        ack_out <= 1'b1;
        @(posedge clk_sys_in);
        ack_out <= 1'b0;
    endtask : ack_pulse
endmodule : iuos_host_model

// [interrupt_unit_operation_status_tb.sv]
/*
 * Self-checking bench for the interrupt unit operation and status block.
 * Assumes iuos_top and the host model; expected bytes are worked out here.
 */
module interrupt_unit_operation_status_tb
    import iuos_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys_in;     // 50 MHz system clock
    logic       reset_in;       // Active high reset
    logic [7:0] irq_pin_in;     // Request pins
    logic       auto_finish_in; // Automatic finish select
    logic       sel, addr, wr, rd, ack; // Host strobes
    logic [7:0] wdata;          // Host write byte
    logic [7:0] rdata_out;      // Unit read byte
    logic       int_out;        // Unit request to the host
    logic [2:0] ack_level_out;  // Granted level
    logic [7:0] d;              // Scratch read byte
    int         bad_count;      // Mismatches
    int         checked;        // Comparisons
    int         cycles;         // Hang guard

    ////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    iuos_top dut_u (
        .clk_sys_in    (clk_sys_in),
        .reset_in      (reset_in),
        .irq_pin_in    (irq_pin_in),
        .sel_in        (sel),
        .addr_in       (addr),
        .wr_in         (wr),
        .rd_in         (rd),
        .wdata_in      (wdata),
        .ack_in        (ack),
        .auto_finish_in(auto_finish_in),
        .rdata_out     (rdata_out),
        .int_out       (int_out),
        .ack_level_out (ack_level_out)
    );

    iuos_host_model host_u (
        .clk_sys_in(clk_sys_in),
        .rdata_in  (rdata_out),
        .sel_out   (sel),
        .addr_out  (addr),
        .wr_out    (wr),
        .rd_out    (rd),
        .wdata_out (wdata),
        .ack_out   (ack)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic rdchk(input logic a, input logic [7:0] exp);
        host_u.read_port(a, d);
        chk(d, exp);
    endtask : rdchk

    task automatic pollchk(input logic [7:0] exp);
        host_u.poll_read(d);
        chk(d, exp);
    endtask : pollchk

    // Bounded wait: the synchroniser takes a few cycles to show a pin
    task automatic wait_int(input logic e);
        for (int n = 0; n < 20 && int_out !== e; n++) begin
            @(posedge clk_sys_in);
        end
        chk({7'h00, int_out}, {7'h00, e});
    endtask : wait_int

    task automatic wrap_up();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard, well above the hundred-odd cycles the run needs
    initial cycles = 0;
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_in       = 1'b1;
        irq_pin_in     = 8'h00;
        auto_finish_in = 1'b0;
        bad_count      = 0;
        checked        = 0;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rdchk(PORT_CMD_STATUS, RDATA_RST);
        rdchk(PORT_MASK, MASK_RST);
        // Requests on levels 1, 3 and 5
        @(posedge clk_sys_in);
        irq_pin_in <= 8'h2a;
        wait_int(1'b1);
        host_u.write_port(PORT_CMD_STATUS, 8'h0a);
        rdchk(PORT_CMD_STATUS, 8'h2a);
        rdchk(PORT_CMD_STATUS, 8'h2a);
        pollchk(8'h81);
        rdchk(PORT_CMD_STATUS, 8'h81);
        // Grant level 1, it moves to in-service
        host_u.ack_pulse();
        @(posedge clk_sys_in);
        chk({5'h00, ack_level_out}, 8'h01);
        host_u.write_port(PORT_CMD_STATUS, 8'h0b);
        rdchk(PORT_CMD_STATUS, 8'h02);
        host_u.write_port(PORT_CMD_STATUS, 8'h0a);
        rdchk(PORT_CMD_STATUS, 8'h28);
        chk({7'h00, int_out}, 8'h00);
        // Non-specific finish empties service
        host_u.write_port(PORT_CMD_STATUS, 8'h20);
        host_u.write_port(PORT_CMD_STATUS, 8'h0b);
        rdchk(PORT_CMD_STATUS, 8'h00);
        wait_int(1'b1);
        host_u.ack_pulse();
        @(posedge clk_sys_in);
        chk({5'h00, ack_level_out}, 8'h03);
        // Specific finish of a level not in service changes nothing
        host_u.write_port(PORT_CMD_STATUS, 8'h65);
        rdchk(PORT_CMD_STATUS, 8'h08);
        host_u.write_port(PORT_CMD_STATUS, 8'h63);
        rdchk(PORT_CMD_STATUS, 8'h00);
        // Level 0 joins level 5; rotation makes level 4 lowest
        @(posedge clk_sys_in);
        irq_pin_in <= 8'h2b;
        // Level 5 already drives int_out; let level 0 pass the synchroniser
        repeat (4) @(posedge clk_sys_in);
        wait_int(1'b1);
        pollchk(8'h80);
        host_u.write_port(PORT_CMD_STATUS, 8'hc4);
        pollchk(8'h85);
        // Masked requests stay latched but are not offered
        host_u.write_port(PORT_MASK, 8'h21);
        rdchk(PORT_MASK, 8'h21);
        chk({7'h00, int_out}, 8'h00);
        pollchk(POLL_EMPTY);
        host_u.write_port(PORT_CMD_STATUS, 8'h0a);
        rdchk(PORT_CMD_STATUS, 8'h21);
        // Automatic finish: granted level never shows in service
        host_u.write_port(PORT_MASK, 8'h00);
        auto_finish_in <= 1'b1;
        wait_int(1'b1);
        host_u.ack_pulse();
        @(posedge clk_sys_in);
        chk({5'h00, ack_level_out}, 8'h05);
        host_u.write_port(PORT_CMD_STATUS, 8'h0b);
        rdchk(PORT_CMD_STATUS, 8'h00);
        // Nesting: a lower level is offered only while nesting is on
        auto_finish_in <= 1'b0;
        host_u.ack_pulse();
        @(posedge clk_sys_in);
        chk({5'h00, ack_level_out}, 8'h00);
        @(posedge clk_sys_in);
        irq_pin_in <= 8'h2f;
        repeat (4) @(posedge clk_sys_in);
        chk({7'h00, int_out}, 8'h00);
        host_u.write_port(PORT_CMD_STATUS, 8'h68);
        wait_int(1'b1);
        host_u.ack_pulse();
        @(posedge clk_sys_in);
        chk({5'h00, ack_level_out}, 8'h02);
        rdchk(PORT_CMD_STATUS, 8'h05);
        wrap_up();
    end
endmodule : interrupt_unit_operation_status_tb
